// ===== src/asp_pkg.sv
// -----------------------------------------------------------------------------
// -----------------------------------------------------------------------------
package asp_pkg;

	// -------------------------------------------------------------------------
	// Device control port
	// -------------------------------------------------------------------------
	localparam logic [7:0] ASP_CTRL_ADDR  = 8'h98;
	localparam logic [7:0] ASP_BUF_ADDR   = 8'h99;
	localparam logic [7:0] ASP_CTRL_RESET = 8'h40;
	localparam int         ASP_BIT_MODE   = 7;
	localparam int         ASP_BIT_UNUSED = 6;
	localparam int         ASP_BIT_MCE    = 5;
	localparam int         ASP_BIT_REN    = 4;
	localparam int         ASP_BIT_TB8    = 3;
	localparam int         ASP_BIT_RB8    = 2;
	localparam int         ASP_BIT_TI     = 1;
	localparam int         ASP_BIT_RI     = 0;

	// -------------------------------------------------------------------------
	// Frame layout
	// -------------------------------------------------------------------------
	localparam logic [3:0] ASP_STOP_IDX8  = 4'h9;
	localparam logic [3:0] ASP_STOP_IDX9  = 4'ha;
	localparam logic [3:0] ASP_DATA_BITS8 = 4'h8;
	localparam logic [3:0] ASP_DATA_BITS9 = 4'h9;

	// -------------------------------------------------------------------------
	// Partner registers on AHB-Lite
	// -------------------------------------------------------------------------
	localparam logic [7:0]  ASP_P_CTRL     = 8'h00;
	localparam logic [7:0]  ASP_P_DIV      = 8'h04;
	localparam logic [7:0]  ASP_P_TXDATA   = 8'h08;
	localparam logic [7:0]  ASP_P_RXDATA   = 8'h0c;
	localparam logic [7:0]  ASP_P_STATUS   = 8'h10;
	localparam logic [15:0] ASP_P_DIV_RESET = 16'h0010;

	typedef enum logic [1:0] {
		ASP_RX_IDLE,
		ASP_RX_START,
		ASP_RX_DATA,
		ASP_RX_STOP
	} asp_rx_t;

endpackage

// ===== src/asp_link_if.sv
`timescale 1ns/1ps
// -----------------------------------------------------------------------------
// Serial lines between the two nodes
// -----------------------------------------------------------------------------
interface asp_link_if;
	logic devToFar;
	logic farToDev;

	modport dev (
		output devToFar,
		input  farToDev
	);
	modport far (
		input  devToFar,
		output farToDev
	);
endinterface

// ===== src/asp_device.sv
`timescale 1ns/1ps
module asp_device
	import asp_pkg::*;
(
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       nrst,
	// Control port
	input  wire logic [7:0] sfrAddr,
	input  wire logic       sfrWr,
	input  wire logic       sfrRd,
	input  wire logic [7:0] sfrWdata,
	output logic      [7:0] sfrRdata,
	// Baud timer and interrupt
	input  wire logic       timerOvf,
	input  wire logic       irqEn,
	output logic            irq,
	// Serial lines
	asp_link_if.dev         link
);

	typedef struct packed {
		logic       mode;
		logic       mce;
		logic       ren;
		logic       tb8;
		logic       rb8;
		logic       ti;
		logic       ri;
		logic [7:0] rxBuf;
		logic [10:0] txFrame;
		logic [3:0] txCnt;
		logic       txBusy;
		logic       txHalf;
		logic       txLine;
		asp_rx_t    rxSt;
		logic [8:0] rxShift;
		logic [3:0] rxCnt;
		logic       rxHalf;
		logic       rxPrev;
		logic [7:0] rdata;
		logic       irq;
	} asp_dev_state_t;

	asp_dev_state_t s_reg;
	asp_dev_state_t s_next;
	logic           txTick;
	logic           rxSample;
	logic [3:0]     stopIdx;
	logic [3:0]     dataBits;
	logic [7:0]     rxByte;
	logic           rxNinth;
	logic           accept;
	logic [7:0]     ctrlView;

	assign sfrRdata      = s_reg.rdata;
	assign irq           = s_reg.irq;
	assign link.devToFar = s_reg.txLine;

	// -------------------------------------------------------------------------
	// Next state
	// -------------------------------------------------------------------------
	always_comb begin
		s_next   = s_reg;
		txTick   = timerOvf & s_reg.txHalf;
		rxSample = timerOvf & ~s_reg.rxHalf;
		stopIdx  = s_reg.mode ? ASP_STOP_IDX9 : ASP_STOP_IDX8;
		dataBits = s_reg.mode ? ASP_DATA_BITS9 : ASP_DATA_BITS8;
		rxByte   = s_reg.mode ? s_reg.rxShift[7:0] : s_reg.rxShift[8:1];
		rxNinth  = s_reg.mode ? s_reg.rxShift[8] : link.farToDev;
		accept   = ~s_reg.ri & (~s_reg.mce | rxNinth);
		ctrlView = {s_reg.mode, 1'b1, s_reg.mce, s_reg.ren,
			s_reg.tb8, s_reg.rb8, s_reg.ti, s_reg.ri};

		s_next.rxPrev = link.farToDev;
		if (timerOvf) begin
			s_next.txHalf = ~s_reg.txHalf;
			s_next.rxHalf = ~s_reg.rxHalf;
		end

		// ---------------------------------------------------------------------
		// Software access
		// ---------------------------------------------------------------------
		if (sfrWr && sfrAddr == ASP_CTRL_ADDR) begin
			s_next.mode = sfrWdata[ASP_BIT_MODE];
			s_next.mce  = sfrWdata[ASP_BIT_MCE];
			s_next.ren  = sfrWdata[ASP_BIT_REN];
			s_next.tb8  = sfrWdata[ASP_BIT_TB8];
			s_next.rb8  = sfrWdata[ASP_BIT_RB8];
			s_next.ti   = sfrWdata[ASP_BIT_TI];
			s_next.ri   = sfrWdata[ASP_BIT_RI];
		end
		if (sfrWr && sfrAddr == ASP_BUF_ADDR && !s_reg.txBusy) begin
			s_next.txFrame = s_reg.mode ?
				{1'b1, s_reg.tb8, sfrWdata, 1'b0} :
				{2'b11, sfrWdata, 1'b0};
			s_next.txLine  = 1'b0;
			s_next.txBusy  = 1'b1;
			s_next.txCnt   = 4'h0;
			s_next.txHalf  = 1'b0;
		end
		if (sfrRd) begin
			if (sfrAddr == ASP_CTRL_ADDR) begin
				s_next.rdata = ctrlView;
			end else if (sfrAddr == ASP_BUF_ADDR) begin
				s_next.rdata = s_reg.rxBuf;
			end else begin
				s_next.rdata = 8'h00;
			end
		end

		// ---------------------------------------------------------------------
		// Transmitter
		// ---------------------------------------------------------------------
		if (s_reg.txBusy && txTick) begin
			if (s_reg.txCnt == stopIdx) begin
				s_next.txBusy = 1'b0;
			end else begin
				s_next.txFrame = {1'b1, s_reg.txFrame[10:1]};
				s_next.txLine  = s_reg.txFrame[1];
				s_next.txCnt   = s_reg.txCnt + 4'h1;
				if (s_reg.txCnt + 4'h1 == stopIdx) begin
					s_next.ti = 1'b1;
				end
			end
		end

		// ---------------------------------------------------------------------
		// Receiver
		// ---------------------------------------------------------------------
		case (s_reg.rxSt)
			ASP_RX_IDLE: begin
				if (s_reg.ren && s_reg.rxPrev && !link.farToDev) begin
					s_next.rxSt   = ASP_RX_START;
					s_next.rxHalf = 1'b0;
					s_next.rxCnt  = 4'h0;
				end
			end
			ASP_RX_START: begin
				if (rxSample) begin
					s_next.rxSt = link.farToDev ? ASP_RX_IDLE : ASP_RX_DATA;
				end
			end
			ASP_RX_DATA: begin
				if (rxSample) begin
					s_next.rxShift = {link.farToDev, s_reg.rxShift[8:1]};
					s_next.rxCnt   = s_reg.rxCnt + 4'h1;
					if (s_reg.rxCnt + 4'h1 == dataBits) begin
						s_next.rxSt = ASP_RX_STOP;
					end
				end
			end
			ASP_RX_STOP: begin
				if (rxSample) begin
					s_next.rxSt = ASP_RX_IDLE;
					if (accept) begin
						s_next.rxBuf = rxByte;
						s_next.rb8   = rxNinth;
						s_next.ri    = 1'b1;
					end
				end
			end
			default: begin
				s_next.rxSt = ASP_RX_IDLE;
			end
		endcase

		s_next.irq = irqEn & (s_reg.ti | s_reg.ri);
	end

	// -------------------------------------------------------------------------
	// State register
	// -------------------------------------------------------------------------
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			s_reg         <= '0;
			s_reg.mode    <= ASP_CTRL_RESET[ASP_BIT_MODE];
			s_reg.txFrame <= 11'h7ff;
			s_reg.txLine  <= 1'b1;
			s_reg.rxSt    <= ASP_RX_IDLE;
			s_reg.rxPrev  <= 1'b1;
		end else begin
			s_reg <= s_next;
		end
	end

endmodule

// ===== src/asp_partner.sv
`timescale 1ns/1ps
module asp_partner
	import asp_pkg::*;
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        nrst,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic      [31:0] hrdata,
	// Serial lines
	asp_link_if.far          link
);

	typedef struct packed {
		logic        nine;
		logic        tb8;
		logic [15:0] div;
		logic [10:0] txFrame;
		logic [3:0]  txCnt;
		logic        txBusy;
		logic        txLine;
		logic [15:0] txTimer;
		asp_rx_t     rxSt;
		logic [8:0]  rxShift;
		logic [3:0]  rxCnt;
		logic [15:0] rxTimer;
		logic        rxPrev;
		logic [7:0]  rxData;
		logic        rxNinth;
		logic        rxValid;
		logic        rxOverrun;
		logic        apWr;
		logic [7:0]  apAddr;
		logic [31:0] hrdata;
		logic        hreadyout;
	} asp_far_state_t;

	asp_far_state_t s_reg;
	asp_far_state_t s_next;
	logic           addrPhase;
	logic           rxTick;
	logic [3:0]     stopIdx;
	logic [3:0]     dataBits;

	assign hreadyout     = s_reg.hreadyout;
	assign hresp         = 1'b0;
	assign hrdata        = s_reg.hrdata;
	assign link.farToDev = s_reg.txLine;

	// -------------------------------------------------------------------------
	// Next state
	// -------------------------------------------------------------------------
	always_comb begin
		s_next    = s_reg;
		addrPhase = hsel & htrans[1] & hready;
		rxTick    = s_reg.rxTimer == 16'h0000;
		stopIdx   = s_reg.nine ? ASP_STOP_IDX9 : ASP_STOP_IDX8;
		dataBits  = s_reg.nine ? ASP_DATA_BITS9 : ASP_DATA_BITS8;
		s_next.hreadyout = 1'b1;
		s_next.rxPrev    = link.devToFar;
		s_next.apWr      = addrPhase & hwrite;
		s_next.apAddr    = haddr[7:0];

		// ---------------------------------------------------------------------
		// Bus access
		// ---------------------------------------------------------------------
		if (addrPhase && !hwrite) begin
			case (haddr[7:0])
				ASP_P_CTRL:   s_next.hrdata = {30'h0, s_reg.tb8, s_reg.nine};
				ASP_P_DIV:    s_next.hrdata = {16'h0, s_reg.div};
				ASP_P_RXDATA: s_next.hrdata = {24'h0, s_reg.rxData};
				ASP_P_STATUS: s_next.hrdata = {28'h0, s_reg.rxOverrun, s_reg.rxNinth,
					s_reg.rxValid, s_reg.txBusy};
				default:      s_next.hrdata = 32'h0;
			endcase
			if (haddr[7:0] == ASP_P_RXDATA) begin
				s_next.rxValid   = 1'b0;
				s_next.rxOverrun = 1'b0;
			end
		end
		if (s_reg.apWr) begin
			if (s_reg.apAddr == ASP_P_CTRL) begin
				s_next.nine = hwdata[0];
				s_next.tb8  = hwdata[1];
			end
			if (s_reg.apAddr == ASP_P_DIV) begin
				s_next.div = hwdata[15:0];
			end
			if (s_reg.apAddr == ASP_P_TXDATA && !s_reg.txBusy) begin
				s_next.txFrame = s_reg.nine ? {1'b1, s_reg.tb8, hwdata[7:0], 1'b0} :
					{2'b11, hwdata[7:0], 1'b0};
				s_next.txLine  = 1'b0;
				s_next.txBusy  = 1'b1;
				s_next.txCnt   = 4'h0;
				s_next.txTimer = s_reg.div - 16'h0001;
			end
		end

		// ---------------------------------------------------------------------
		// Transmitter
		// ---------------------------------------------------------------------
		if (s_reg.txBusy) begin
			if (s_reg.txTimer != 16'h0000) begin
				s_next.txTimer = s_reg.txTimer - 16'h0001;
			end else if (s_reg.txCnt == stopIdx) begin
				s_next.txBusy = 1'b0;
			end else begin
				s_next.txTimer = s_reg.div - 16'h0001;
				s_next.txFrame = {1'b1, s_reg.txFrame[10:1]};
				s_next.txLine  = s_reg.txFrame[1];
				s_next.txCnt   = s_reg.txCnt + 4'h1;
			end
		end

		// ---------------------------------------------------------------------
		// Receiver
		// ---------------------------------------------------------------------
		if (s_reg.rxSt != ASP_RX_IDLE) begin
			s_next.rxTimer = rxTick ? s_reg.div - 16'h0001 : s_reg.rxTimer - 16'h0001;
		end
		case (s_reg.rxSt)
			ASP_RX_IDLE: begin
				if (s_reg.rxPrev && !link.devToFar) begin
					s_next.rxSt    = ASP_RX_START;
					// Sample early: the device start bit may be up to three cycles short
					s_next.rxTimer = {1'b0, s_reg.div[15:1]} - 16'h0002;
					s_next.rxCnt   = 4'h0;
				end
			end
			ASP_RX_START: begin
				if (rxTick) begin
					s_next.rxSt = link.devToFar ? ASP_RX_IDLE : ASP_RX_DATA;
				end
			end
			ASP_RX_DATA: begin
				if (rxTick) begin
					s_next.rxShift = {link.devToFar, s_reg.rxShift[8:1]};
					s_next.rxCnt   = s_reg.rxCnt + 4'h1;
					if (s_reg.rxCnt + 4'h1 == dataBits) begin
						s_next.rxSt = ASP_RX_STOP;
					end
				end
			end
			ASP_RX_STOP: begin
				if (rxTick) begin
					s_next.rxSt      = ASP_RX_IDLE;
					s_next.rxData    = s_reg.nine ? s_reg.rxShift[7:0] : s_reg.rxShift[8:1];
					s_next.rxNinth   = s_reg.nine ? s_reg.rxShift[8] : link.devToFar;
					s_next.rxOverrun = s_reg.rxValid;
					s_next.rxValid   = 1'b1;
				end
			end
			default: begin
				s_next.rxSt = ASP_RX_IDLE;
			end
		endcase
	end

	// -------------------------------------------------------------------------
	// State register
	// -------------------------------------------------------------------------
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			s_reg         <= '0;
			s_reg.div     <= ASP_P_DIV_RESET;
			s_reg.txFrame <= 11'h7ff;
			s_reg.txLine  <= 1'b1;
			s_reg.rxSt    <= ASP_RX_IDLE;
			s_reg.rxPrev  <= 1'b1;
		end else begin
			s_reg <= s_next;
		end
	end

endmodule

// ===== verif/asp_link_sva.sv
`timescale 1ns/1ps
// ------------
// Line checks
// ------------
module asp_link_sva (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Serial lines
	input wire logic devToFar,
	input wire logic farToDev
);
	logic [6:0] devHi_reg;
	logic [6:0] farHi_reg;

	// High run length, saturating
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			devHi_reg <= 7'h7f;
			farHi_reg <= 7'h7f;
		end else begin
			devHi_reg <= !devToFar ? 7'h00 : devHi_reg + {6'h00, devHi_reg != 7'h7f};
			farHi_reg <= !farToDev ? 7'h00 : farHi_reg + {6'h00, farHi_reg != 7'h7f};
		end
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);

	// Frame start after a long idle
	sequence devStart;
		$fell(devToFar) && devHi_reg >= 7'h58;
	endsequence
	sequence farStart;
		$fell(farToDev) && farHi_reg >= 7'h58;
	endsequence

	chk_idle_after_reset: assert property ($rose(nrst) |-> devToFar && farToDev)
		else $error("line not idle after reset");
	chk_far_bit_hold: assert property ($changed(farToDev) |=> $stable(farToDev)[*7])
		else $error("far bit shorter than eight cycles");
	chk_dev_rise_hold: assert property ($rose(devToFar) |=> $stable(devToFar)[*7])
		else $error("device high bit shorter than two overflows");
	chk_dev_fall_hold: assert property ($fell(devToFar) |=> !devToFar[*3])
		else $error("device low bit too short");
	chk_dev_low_max: assert property ($fell(devToFar) |-> ##[4:84] devToFar)
		else $error("device line low too long");
	chk_far_low_max: assert property ($fell(farToDev) |-> ##[8:80] farToDev)
		else $error("far line low too long");
	chk_far_stop_place: assert property (farStart |-> ##72 (farToDev or ##8 farToDev))
		else $error("far stop bit misplaced");
	chk_dev_frame_end: assert property (devStart |-> ##88 devToFar)
		else $error("device frame too long");
endmodule

// ===== verif/testbench.sv
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin errorCnt++; \
	$display("ERROR %0t got %h exp %h", $time, (a), (b)); end end
module testbench
	import asp_pkg::*;
;
	localparam logic [7:0] MODE9 = 8'h01 << ASP_BIT_MODE;
	localparam logic [7:0] ONE6  = 8'h01 << ASP_BIT_UNUSED;
	localparam logic [7:0] FILT  = 8'h01 << ASP_BIT_MCE;
	localparam logic [7:0] RXEN  = 8'h01 << ASP_BIT_REN;
	localparam logic [7:0] TX9   = 8'h01 << ASP_BIT_TB8;
	localparam logic [7:0] RX9   = 8'h01 << ASP_BIT_RB8;
	localparam logic [7:0] TDONE = 8'h01 << ASP_BIT_TI;
	localparam logic [7:0] RDONE = 8'h01 << ASP_BIT_RI;

	logic        clk;
	logic        nrst;
	logic [7:0]  sfrAddr;
	logic        sfrWr;
	logic        sfrRd;
	logic [7:0]  sfrWdata;
	logic [7:0]  sfrRdata;
	logic        timerOvf;
	logic        irqEn;
	logic        irq;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	logic        hreadyout;
	logic        hresp;
	logic [31:0] hrdata;
	logic [1:0]  ovfCnt = 2'h0;
	int          errorCnt = 0;
	int          comparisons = 0;

	asp_link_if asp_link_if_i ();
	asp_device asp_device_i (.clk(clk), .nrst(nrst), .sfrAddr(sfrAddr), .sfrWr(sfrWr),
		.sfrRd(sfrRd), .sfrWdata(sfrWdata), .sfrRdata(sfrRdata), .timerOvf(timerOvf),
		.irqEn(irqEn), .irq(irq), .link(asp_link_if_i.dev));
	asp_partner asp_partner_i (.clk(clk), .nrst(nrst), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .link(asp_link_if_i.far));
	asp_link_sva asp_link_sva_i (.clk(clk), .nrst(nrst), .devToFar(asp_link_if_i.devToFar),
		.farToDev(asp_link_if_i.farToDev));

	// ------------
	// Clock and baud tick
	// ------------
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	always @(posedge clk) begin
		ovfCnt   <= ovfCnt + 2'h1;
		timerOvf <= (ovfCnt == 2'h3);
	end

	// ------------
	// Bus tasks
	// ------------
	task automatic sfrW(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		sfrAddr  <= a;
		sfrWdata <= d;
		sfrWr    <= 1'b1;
		@(posedge clk);
		sfrWr <= 1'b0;
	endtask
	task automatic sfrR(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		sfrAddr <= a;
		sfrRd   <= 1'b1;
		@(posedge clk);
		sfrRd <= 1'b0;
		@(negedge clk);
		d = sfrRdata;
	endtask
	task automatic ahbX(input logic w, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		@(posedge clk);
		hsel   <= 1'b1;
		htrans <= 2'h2;
		haddr  <= {24'h000000, a};
		hwrite <= w;
		do @(posedge clk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge clk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	task automatic farSend(input logic [7:0] d);
		logic [31:0] s;
		ahbX(1'b1, ASP_P_TXDATA, {24'h000000, d}, s);
		repeat (60) begin
			ahbX(1'b0, ASP_P_STATUS, 32'h0, s);
			if (s[0] === 1'b0) break;
		end
		repeat (100) @(posedge clk);
	endtask
	task automatic devSend(input logic [7:0] d);
		logic [7:0] c;
		sfrW(ASP_BUF_ADDR, d);
		@(negedge clk);
		`CHK(asp_link_if_i.devToFar, 1'b0)
		repeat (60) begin
			sfrR(ASP_CTRL_ADDR, c);
			if (c[ASP_BIT_TI] === 1'b1) break;
		end
		`CHK(asp_link_if_i.devToFar, 1'b1)
		repeat (100) @(posedge clk);
	endtask
	task automatic ctrlIs(input logic [7:0] e);
		logic [7:0] c;
		sfrR(ASP_CTRL_ADDR, c);
		`CHK(c, e)
	endtask
	task automatic bufIs(input logic [7:0] e);
		logic [7:0] c;
		sfrR(ASP_BUF_ADDR, c);
		`CHK(c, e)
	endtask
	task automatic farGot(input logic [2:0] st, input logic [7:0] d);
		logic [31:0] s;
		ahbX(1'b0, ASP_P_STATUS, 32'h0, s);
		`CHK(s[3:1], st)
		ahbX(1'b0, ASP_P_RXDATA, 32'h0, s);
		`CHK(s[7:0], d)
	endtask

	// ------------
	// Scenarios
	// ------------
	task automatic tReset();
		logic [31:0] s;
		ctrlIs(ASP_CTRL_RESET);
		bufIs(8'h00);
		sfrW(ASP_CTRL_ADDR, 8'h00);
		ctrlIs(ONE6);
		ahbX(1'b0, ASP_P_DIV, 32'h0, s);
		`CHK(s, {16'h0000, ASP_P_DIV_RESET})
		ahbX(1'b0, 8'h14, 32'h0, s);
		`CHK(s, 32'h00000000)
		ahbX(1'b1, ASP_P_DIV, 32'h00000008, s);
	endtask
	task automatic tDevTx();
		irqEn <= 1'b1;
		sfrW(ASP_CTRL_ADDR, TX9);
		devSend(8'ha5);
		`CHK(irq, 1'b1)
		farGot(3'b011, 8'ha5);
		bufIs(8'h00);
		ctrlIs(ONE6 | TX9 | TDONE);
		sfrW(ASP_CTRL_ADDR, 8'h00);
		repeat (2) @(posedge clk);
		@(negedge clk);
		`CHK(irq, 1'b0)
	endtask
	task automatic tRx8();
		logic [31:0] s;
		farSend(8'h3c);
		ctrlIs(ONE6);
		sfrW(ASP_CTRL_ADDR, RXEN);
		farSend(8'h3c);
		ctrlIs(ONE6 | RXEN | RX9 | RDONE);
		farSend(8'hc3);
		bufIs(8'h3c);
		ahbX(1'b1, ASP_P_CTRL, 32'h1, s);
		sfrW(ASP_CTRL_ADDR, RXEN | FILT | RX9);
		farSend(8'h5a);
		ctrlIs(ONE6 | RXEN | FILT | RX9);
		bufIs(8'h3c);
		sfrW(ASP_CTRL_ADDR, RXEN | RX9);
		farSend(8'h5a);
		ctrlIs(ONE6 | RXEN | RDONE);
		bufIs(8'h5a);
	endtask
	task automatic tNine();
		logic [31:0] s;
		sfrW(ASP_CTRL_ADDR, MODE9 | TX9);
		devSend(8'h81);
		farGot(3'b011, 8'h81);
		sfrW(ASP_CTRL_ADDR, MODE9);
		devSend(8'h7e);
		farGot(3'b001, 8'h7e);
		sfrW(ASP_CTRL_ADDR, MODE9 | RXEN | FILT);
		farSend(8'h11);
		ctrlIs(ONE6 | MODE9 | RXEN | FILT);
		ahbX(1'b1, ASP_P_CTRL, 32'h3, s);
		farSend(8'h22);
		ctrlIs(ONE6 | MODE9 | RXEN | FILT | RX9 | RDONE);
		bufIs(8'h22);
		sfrW(ASP_CTRL_ADDR, MODE9 | RXEN | RX9);
		ahbX(1'b1, ASP_P_CTRL, 32'h1, s);
		farSend(8'h33);
		ctrlIs(ONE6 | MODE9 | RXEN | RDONE);
		bufIs(8'h33);
	endtask

	task automatic printVerdict();
		if (errorCnt == 0 && comparisons > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	initial begin
		#200000;
		errorCnt++;
		printVerdict();
	end
	initial begin
		nrst = 1'b0;
		sfrAddr = 8'h00;
		sfrWr = 1'b0;
		sfrRd = 1'b0;
		sfrWdata = 8'h00;
		irqEn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		repeat (16) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		tReset();
		tDevTx();
		tRx8();
		tNine();
		printVerdict();
	end
endmodule
